// file: core_partner.sv
// general data memory seen by the special-function register bank
`timescale 1ns/1ps
module core_partner
(
   input  wire logic [core_sfr_pkg::MEM_ADDR_W-1:0] mem_addr,
   input  wire logic                                sys_clk,
   input  wire logic                                mem_wr,
   input  wire logic [7:0]                          mem_wdata,
   output logic      [7:0]                          mem_rdata
);
   import core_sfr_pkg::*;
   logic [7:0] mem [512];
   // unwritten cells hold an address pattern so stale data is not taken for a hit
   initial for (int i = 0; i < 512; i++) mem[i] = 8'(i ^ 8'hA5);
   // read is combinational, write lands on the clock edge
   assign mem_rdata = mem[mem_addr];
   always @(posedge sys_clk) if (mem_wr) mem[mem_addr] <= mem_wdata;
endmodule // core_partner

// file: core_sfr_bank.sv
// core special-function register bank with program counter, status and port data
//
// Behaviour
// - indirect port accesses register the pointer selects
// - timer0 reads live count, writes replace it
// - timer0 counts instruction, external or low oscillator
// - 11-bit counter, low byte accessible, steps
// - counter top bits load from buffer on low-byte write
// - long jump loads all counter bits
// - long call loads counter, pushes next address
// - status bit 0 holds add overflow
// - status bit 1 holds nibble overflow
// - status bit 2 marks zero result
// - power-down flag set up/clear, cleared sleep
// - timeout flag set up/clear/sleep, cleared timeout
// - status bits 7..6 choose data bank
// - pointer low seven bits pick location; bit7 spare
// - port read gives pin, or latch for output pins by option
// - port writes go to output latches
// - power control watchdog, detect, reset enables
// - pull-high disable bit, spare bits zero reset
// - six wake-up enables, reset to one
// - writing speed-up stop bit stops crystal boost
// - pull-low register holds active-low enables
// - locations below 0x20 ignore bank select
// - indirect address is bank plus pointer
`timescale 1ns/1ps
module core_sfr_bank
   import core_sfr_pkg::*;
(
   input  wire logic                           sys_clk,
   input  wire logic                           reset,
   // operand access from the core
   input  wire logic [core_sfr_pkg::LOC_W-1:0] reg_addr,
   input  wire logic                           reg_rd,
   input  wire logic                           reg_wr,
   input  wire logic [7:0]                     reg_wdata,
   output logic      [7:0]                     reg_rdata,
   output logic                                reg_rvalid,
   // general purpose memory beyond the special area
   output logic [core_sfr_pkg::MEM_ADDR_W-1:0] mem_addr,
   output logic                                mem_wr,
   output logic [7:0]                          mem_wdata,
   input  wire logic [7:0]                     mem_rdata,
   // program flow
   input  wire logic                           inst_done,
   input  wire logic                           long_jump_instruction,
   input  wire logic                           long_call_instruction,
   input  wire logic [core_sfr_pkg::PC_W-1:0]  inst_target,
   output logic [core_sfr_pkg::PC_W-1:0]       pc_out,
   output logic                                stack_push,
   output logic [core_sfr_pkg::PC_W-1:0]       stack_push_addr,
   // arithmetic results and reset causes
   input  wire logic                           alu_flag_we,
   input  wire logic                           alu_carry,
   input  wire logic                           alu_nibble,
   input  wire logic                           zero_flag_we,
   input  wire logic                           alu_zero,
   input  wire logic                           sleep_exec,
   input  wire logic                           clrwdt_exec,
   input  wire logic                           wdt_timeout,
   // timer0 sources
   input  wire logic                           instruction_clock,
   input  wire logic                           external_count_input,
   input  wire logic                           low_osc_clock,
   input  wire logic                           timer0_source_mode,
   input  wire logic                           cfg_t0_low_osc,
   // ports
   input  wire logic [7:0]                     first_io_port_pins,
   input  wire logic [7:0]                     first_io_port_is_out,
   input  wire logic [core_sfr_pkg::SECOND_IO_W-1:0] second_io_port_pins,
   input  wire logic [core_sfr_pkg::SECOND_IO_W-1:0] second_io_port_is_out,
   input  wire logic                           port_readback_option,
   output logic [7:0]                          first_io_port_latch,
   output logic [core_sfr_pkg::SECOND_IO_W-1:0] second_io_port_latch,
   // control outputs
   output logic                                watchdog_enable,
   output logic                                low_voltage_detect_enable,
   output logic                                low_voltage_reset_enable,
   output logic                                pin5_pull_high_disable,
   output logic [core_sfr_pkg::WAKE_W-1:0]     second_port_wakeup_enable,
   output logic                                crystal_speedup_stop,
   output logic [3:0]                          first_port_pull_low_disable,
   output logic [3:0]                          second_port_pull_low_disable,
   output logic [core_sfr_pkg::BANK_W-1:0]     data_bank_select
);
   import core_sfr_pkg::*;

   logic [7:0]        timer0_r;
   logic [PC_W-1:0]   pc_r;
   logic [PCH_W-1:0]  program_counter_high_buffer_r;
   logic [7:0]        status_r;
   logic [7:0]        ptr_r;
   logic [7:0]        first_latch_r;
   logic [7:0]        second_latch_r;
   logic [7:0]        power_control_r;
   logic [WAKE_W-1:0] wake_r;
   logic [7:0]        pull_low_r;
   logic              speedup_stop_r;
   logic              push_r;
   logic [PC_W-1:0]   push_addr_r;
   logic [7:0]        rdata_r;
   logic              rvalid_r;
   logic              ext_prev_r;
   logic              low_prev_r;
   logic [LOC_W-1:0]  eff_loc;
   logic              is_sfr;
   logic              sfr_wr;
   logic              t0_tick;
   t0_src_t           t0_src;
   logic [7:0]        sfr_rdata;
   logic [7:0]        first_rd;
   logic [7:0]        second_rd;

   // effective location: indirect port redirects through the pointer
   assign eff_loc  = (reg_addr == ADDR_INDIRECT_PORT) ? ptr_r[LOC_W-1:0] : reg_addr;
   assign is_sfr   = (eff_loc[LOC_W-1:LOC_W-2] == SFR_AREA_TOP);
   assign sfr_wr   = reg_wr && is_sfr;
   assign mem_addr = {status_r[7:ST_BANK_LO], eff_loc};
   assign mem_wr   = reg_wr && !is_sfr;
   assign mem_wdata = reg_wdata;

   // timer0 source selection and tick
   always_comb
   begin
      if (!timer0_source_mode)
         t0_src = T0_SRC_INST;
      else if (cfg_t0_low_osc)
         t0_src = T0_SRC_LOW;
      else
         t0_src = T0_SRC_EXT;
   end

   always_comb
   begin
      case (t0_src)
         T0_SRC_INST: t0_tick = instruction_clock;
         T0_SRC_EXT:  t0_tick = external_count_input && !ext_prev_r;
         T0_SRC_LOW:  t0_tick = low_osc_clock && !low_prev_r;
         default:     t0_tick = 1'b0;
      endcase
   end

   // edge history for pin-driven timer sources
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ext_prev_r <= 1'b0;
         low_prev_r <= 1'b0;
      end
      else
      begin
         ext_prev_r <= external_count_input;
         low_prev_r <= low_osc_clock;
      end
   end

   // timer0 count: a write wins over a tick
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         timer0_r <= ZERO_BYTE;
      else if (sfr_wr && eff_loc == ADDR_TIMER0_COUNT)
         timer0_r <= reg_wdata;
      else if (t0_tick)
         timer0_r <= timer0_r + 8'h01;
   end

   // program counter and return push
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pc_r        <= PC_RESET;
         push_r      <= 1'b0;
         push_addr_r <= PC_RESET;
      end
      else
      begin
         push_r <= 1'b0;
         if (sfr_wr && eff_loc == ADDR_PC_LOW)
            pc_r <= {program_counter_high_buffer_r, reg_wdata};
         else if (inst_done && long_jump_instruction)
            pc_r <= inst_target;
         else if (inst_done && long_call_instruction)
         begin
            pc_r        <= inst_target;
            push_r      <= 1'b1;
            push_addr_r <= pc_r + 11'h001;
         end
         else if (inst_done)
            pc_r <= pc_r + 11'h001;
      end
   end

   // high buffer and speed-up stop strobe
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         program_counter_high_buffer_r       <= PCH_RESET;
         speedup_stop_r <= 1'b0;
      end
      else
      begin
         speedup_stop_r <= 1'b0;
         if (sfr_wr && eff_loc == ADDR_PC_HIGH_BUF)
         begin
            program_counter_high_buffer_r       <= reg_wdata[PCH_W-1:0];
            speedup_stop_r <= reg_wdata[PCH_SPEEDUP];
         end
      end
   end

   // status: hardware flag events win over a software write
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         status_r                   <= ZERO_BYTE;
         status_r[ST_PDOWN]         <= 1'b1;
         status_r[ST_TIMEOUT]       <= 1'b1;
         status_r[7:ST_BANK_LO]     <= BANK_RESET;
      end
      else
      begin
         if (sfr_wr && eff_loc == ADDR_STATUS_FLAGS)
            status_r <= reg_wdata;
         if (alu_flag_we)
         begin
            status_r[ST_CARRY]  <= alu_carry;
            status_r[ST_NIBBLE] <= alu_nibble;
         end
         if (zero_flag_we)
            status_r[ST_ZERO] <= alu_zero;
         if (sleep_exec)
         begin
            status_r[ST_PDOWN]   <= 1'b0;
            status_r[ST_TIMEOUT] <= 1'b1;
         end
         if (clrwdt_exec)
         begin
            status_r[ST_PDOWN]   <= 1'b1;
            status_r[ST_TIMEOUT] <= 1'b1;
         end
         if (wdt_timeout)
            status_r[ST_TIMEOUT] <= 1'b0;
      end
   end

   // pointer, port latches and control registers
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ptr_r          <= ZERO_BYTE;
         first_latch_r  <= ZERO_BYTE;
         second_latch_r <= ZERO_BYTE;
         power_control_r         <= POWER_CONTROL_RESET;
         wake_r         <= WAKE_RESET;
         pull_low_r     <= PULLLOW_RESET;
      end
      else if (sfr_wr)
      begin
         if (eff_loc == ADDR_INDIRECT_PTR)
            ptr_r <= reg_wdata;
         else if (eff_loc == ADDR_FIRST_PORT)
            first_latch_r <= reg_wdata;
         else if (eff_loc == ADDR_SECOND_PORT)
            second_latch_r <= reg_wdata;
         else if (eff_loc == ADDR_POWER_CONTROL)
            power_control_r <= reg_wdata;
         else if (eff_loc == ADDR_WAKEUP_ENABLE)
            wake_r <= reg_wdata[WAKE_W-1:0];
         else if (eff_loc == ADDR_PULL_LOW_CTRL)
            pull_low_r <= reg_wdata;
      end
   end

   // port read value per pin: input level, or latch for an output pin when option says so
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_first_rd
         assign first_rd[g] = (first_io_port_is_out[g] && port_readback_option)
                              ? first_latch_r[g] : first_io_port_pins[g];
      end
      for (g = 0; g < SECOND_IO_W; g++)
      begin : g_second_rd
         assign second_rd[g] = (second_io_port_is_out[g] && port_readback_option)
                               ? second_latch_r[g] : second_io_port_pins[g];
      end
      for (g = SECOND_IO_W; g < 8; g++)
      begin : g_second_spare
         assign second_rd[g] = second_latch_r[g];
      end
   endgenerate

   // special-area read decode
   always_comb
   begin
      if (eff_loc == ADDR_TIMER0_COUNT)
         sfr_rdata = timer0_r;
      else if (eff_loc == ADDR_PC_LOW)
         sfr_rdata = pc_r[7:0];
      else if (eff_loc == ADDR_STATUS_FLAGS)
         sfr_rdata = status_r;
      else if (eff_loc == ADDR_INDIRECT_PTR)
         sfr_rdata = ptr_r;
      else if (eff_loc == ADDR_FIRST_PORT)
         sfr_rdata = first_rd;
      else if (eff_loc == ADDR_SECOND_PORT)
         sfr_rdata = second_rd;
      else if (eff_loc == ADDR_POWER_CONTROL)
         sfr_rdata = power_control_r;
      else if (eff_loc == ADDR_WAKEUP_ENABLE)
         sfr_rdata = {2'b00, wake_r};
      else if (eff_loc == ADDR_PC_HIGH_BUF)
         sfr_rdata = {5'b00000, program_counter_high_buffer_r};
      else if (eff_loc == ADDR_PULL_LOW_CTRL)
         sfr_rdata = pull_low_r;
      else
         sfr_rdata = ZERO_BYTE;
   end

   // registered read answer, one cycle after the request
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rdata_r  <= ZERO_BYTE;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rvalid_r <= reg_rd;
         if (reg_rd)
            rdata_r <= is_sfr ? sfr_rdata : mem_rdata;
      end
   end

   assign reg_rdata                    = rdata_r;
   assign reg_rvalid                   = rvalid_r;
   assign pc_out                       = pc_r;
   assign stack_push                   = push_r;
   assign stack_push_addr              = push_addr_r;
   assign first_io_port_latch          = first_latch_r;
   assign second_io_port_latch         = second_latch_r[SECOND_IO_W-1:0];
   assign watchdog_enable              = power_control_r[PW_WDT];
   assign low_voltage_detect_enable    = power_control_r[PW_LVD];
   assign low_voltage_reset_enable     = power_control_r[PW_LVR];
   assign pin5_pull_high_disable       = power_control_r[PW_PULLHI5];
   assign second_port_wakeup_enable    = wake_r;
   assign crystal_speedup_stop         = speedup_stop_r;
   assign first_port_pull_low_disable  = pull_low_r[3:0];
   assign second_port_pull_low_disable = pull_low_r[7:4];
   assign data_bank_select             = status_r[7:ST_BANK_LO];

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_call_taken;
      inst_done && long_call_instruction && !long_jump_instruction
         && !(sfr_wr && eff_loc == ADDR_PC_LOW);
   endsequence
   sequence s_push_seen(logic [PC_W-1:0] ret);
      push_r && push_addr_r == ret;
   endsequence

   // pointer aimed at power control: the port must answer with that register
   property p_indirect_redirect;
      reg_rd && reg_addr == ADDR_INDIRECT_PORT && ptr_r[LOC_W-1:0] == ADDR_POWER_CONTROL
         |=> reg_rvalid && reg_rdata == $past(power_control_r);
   endproperty
   a_indirect_redirect: assert property (p_indirect_redirect) else $error("indirect read wrong");

   property p_timer_write;
      sfr_wr && eff_loc == ADDR_TIMER0_COUNT |=> timer0_r == $past(reg_wdata);
   endproperty
   a_timer_write: assert property (p_timer_write) else $error("timer0 write lost");

   property p_pc_step;
      inst_done && !long_jump_instruction && !long_call_instruction && !sfr_wr
         |=> pc_r == $past(pc_r) + 11'h001;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step");

   property p_pcl_load;
      sfr_wr && eff_loc == ADDR_PC_LOW |=> pc_r == {$past(program_counter_high_buffer_r), $past(reg_wdata)};
   endproperty
   a_pcl_load: assert property (p_pcl_load) else $error("pc high not from buffer");

   property p_long_jump;
      inst_done && long_jump_instruction && !sfr_wr |=> pc_r == $past(inst_target);
   endproperty
   a_long_jump: assert property (p_long_jump) else $error("long jump target wrong");

   property p_long_call;
      logic [PC_W-1:0] ret;
      (s_call_taken, ret = pc_r + 11'h001)
         |=> s_push_seen(ret) ##1 (!push_r || $past(inst_done && long_call_instruction));
   endproperty
   a_long_call: assert property (p_long_call) else $error("call push wrong");

   property p_sleep_flags;
      sleep_exec && !clrwdt_exec && !wdt_timeout
         |=> !status_r[ST_PDOWN] && status_r[ST_TIMEOUT];
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

   property p_timeout_flag;
      wdt_timeout |=> !status_r[ST_TIMEOUT];
   endproperty
   a_timeout_flag: assert property (p_timeout_flag) else $error("timeout flag not cleared");

   property p_carry_flags;
      alu_flag_we |=> status_r[ST_CARRY] == $past(alu_carry)
                      && status_r[ST_NIBBLE] == $past(alu_nibble);
   endproperty
   a_carry_flags: assert property (p_carry_flags) else $error("carry flags wrong");

   property p_bank_ignored;
      reg_rd && reg_addr == ADDR_STATUS_FLAGS |=> reg_rdata == $past(status_r);
   endproperty
   a_bank_ignored: assert property (p_bank_ignored) else $error("sfr read depends on bank");

   property p_unused_zero;
      reg_rd && reg_addr == ADDR_WAKEUP_ENABLE |=> reg_rdata[7:WAKE_W] == 2'b00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

endmodule // core_sfr_bank

// file: core_sfr_bank_tb_top.sv
// self-checking bench for the core special-function register bank
`timescale 1ns/1ps
module core_sfr_bank_tb_top;
   import core_sfr_pkg::*;
   logic sys_clk = 0, reset = 1, reg_rd = 0, reg_wr = 0, inst_done = 0, alu_zero = 0;
   logic long_jump_instruction = 0, long_call_instruction = 0, alu_flag_we = 0;
   logic alu_carry = 0, alu_nibble = 0, zero_flag_we = 0, sleep_exec = 0, clrwdt_exec = 0;
   logic wdt_timeout = 0, instruction_clock = 0, external_count_input = 0, low_osc_clock = 0;
   logic timer0_source_mode = 0, cfg_t0_low_osc = 0, port_readback_option = 0;
   logic [6:0]  reg_addr = 0;
   logic [7:0]  reg_wdata = 0, first_io_port_pins = 0, first_io_port_is_out = 0;
   logic [5:0]  second_io_port_pins = 0, second_io_port_is_out = 0;
   logic [10:0] inst_target = 0, pc_out, stack_push_addr, t;
   logic [7:0]  reg_rdata, mem_wdata, mem_rdata, first_io_port_latch, a, b, d;
   logic reg_rvalid, mem_wr, stack_push, watchdog_enable, low_voltage_detect_enable;
   logic low_voltage_reset_enable, pin5_pull_high_disable, crystal_speedup_stop;
   logic [8:0]  mem_addr;
   logic [5:0]  second_io_port_latch, second_port_wakeup_enable;
   logic [3:0]  first_port_pull_low_disable, second_port_pull_low_disable;
   logic [1:0]  data_bank_select;
   int mismatches = 0, check_count = 0, seed = 32'hc298;
   logic [6:0]  ra [9] = '{7'h02, 7'h03, 7'h04, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h07, 7'h1F};
   logic [7:0]  rv [9] = '{8'h00, 8'h18, 8'h00, 8'h98, 8'h3F, 8'h00, 8'hFF, 8'h00, 8'h00};
   logic [2:0]  ev_set [3] = '{3'b010, 3'b100, 3'b001};
   logic [1:0]  ev_flag [3] = '{2'b11, 2'b10, 2'b00};

   core_sfr_bank core_sfr_bank_i (.sys_clk, .reset, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
      .reg_rdata, .reg_rvalid, .mem_addr, .mem_wr, .mem_wdata, .mem_rdata, .inst_done,
      .long_jump_instruction, .long_call_instruction, .inst_target, .pc_out, .stack_push,
      .stack_push_addr, .alu_flag_we, .alu_carry, .alu_nibble, .zero_flag_we, .alu_zero,
      .sleep_exec, .clrwdt_exec, .wdt_timeout, .instruction_clock, .external_count_input,
      .low_osc_clock, .timer0_source_mode, .cfg_t0_low_osc, .first_io_port_pins,
      .first_io_port_is_out, .second_io_port_pins, .second_io_port_is_out,
      .port_readback_option, .first_io_port_latch, .second_io_port_latch, .watchdog_enable,
      .low_voltage_detect_enable, .low_voltage_reset_enable, .pin5_pull_high_disable,
      .second_port_wakeup_enable, .crystal_speedup_stop, .first_port_pull_low_disable,
      .second_port_pull_low_disable, .data_bank_select);
   core_partner core_partner_i (.sys_clk, .mem_addr, .mem_wr, .mem_wdata, .mem_rdata);

   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   // compare one observed value with its expectation
   task automatic chk(input string n, input logic [10:0] got, input logic [10:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   // register write, one strobe cycle
   task automatic wr(input logic [6:0] ad, input logic [7:0] v);
      @(negedge sys_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, ad, v};
      @(negedge sys_clk) reg_wr = 1'b0;
   endtask
   // register read, answer one cycle after the strobe
   task automatic rd(input logic [6:0] ad, input logic [7:0] e);
      @(negedge sys_clk) {reg_rd, reg_addr} = {1'b1, ad};
      @(negedge sys_clk) reg_rd = 1'b0;
      chk("reg_rvalid", reg_rvalid, 1'b1);
      chk("reg_rdata", reg_rdata, e);
   endtask
   // one-cycle reset-cause events: sleep, watchdog clear, timeout
   task automatic ev(input logic [2:0] e);
      @(negedge sys_clk) {sleep_exec, clrwdt_exec, wdt_timeout} = e;
      @(negedge sys_clk) {sleep_exec, clrwdt_exec, wdt_timeout} = 3'b000;
   endtask
   task automatic tdone(input string n);
      $display("test %s done", n);
   endtask
   // input pins read as pins, output pins as latch or pin by option
   function automatic logic [7:0] pexp(input logic [7:0] p, o, l, input logic opt);
      return (p & ~o) | (o & (opt ? l : p));
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // hang guard, the tests need well under 2000 cycles
   initial
   begin
      #20000;
      mismatches++;
      final_report();
   end

   // main sequence
   initial
   begin
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      foreach (ra[i]) rd(ra[i], rv[i]);
      chk("power", {watchdog_enable, low_voltage_detect_enable, pin5_pull_high_disable,
         low_voltage_reset_enable}, 4'b1011);
      chk("wakeup", second_port_wakeup_enable, 6'h3F);
      chk("pull_low", {second_port_pull_low_disable, first_port_pull_low_disable}, 8'hFF);
      chk("pc", pc_out, 11'h000);
      tdone("reset");
      repeat (4)
      begin
         a = 8'($random(seed));
         wr(7'h08, a);
         rd(7'h08, a);
         chk("power", {watchdog_enable, low_voltage_detect_enable, pin5_pull_high_disable,
            low_voltage_reset_enable}, {a[7], a[5], a[4], a[3]});
         wr(7'h09, a);
         rd(7'h09, a & 8'h3F);
         chk("wakeup", second_port_wakeup_enable, a[5:0]);
         wr(7'h0B, ~a);
         chk("pull_low", {second_port_pull_low_disable, first_port_pull_low_disable}, 8'(~a));
         wr(7'h07, a);
         rd(7'h07, 8'h00);
      end
      tdone("control");
      wr(7'h03, 8'hE7);
      rd(7'h03, 8'hE7);
      chk("bank", data_bank_select, 2'h3);
      a = 8'($random(seed));
      @(negedge sys_clk) {alu_flag_we, zero_flag_we, alu_carry, alu_nibble, alu_zero} = {2'b11, a[2:0]};
      @(negedge sys_clk) {alu_flag_we, zero_flag_we} = 2'b00;
      rd(7'h03, {5'b11100, a[0], a[1], a[2]});
      foreach (ev_set[i])
      begin
         ev(ev_set[i]);
         rd(7'h03, {3'b111, ev_flag[i], a[0], a[1], a[2]});
      end
      tdone("status");
      wr(7'h03, 8'h58);
      d = 8'($random(seed));
      wr(7'h04, 8'hA5);
      wr(7'h00, d);
      chk("memory", core_partner_i.mem[9'h0A5], d);
      rd(7'h00, d);
      rd(7'h04, 8'hA5);
      wr(7'h04, 8'h08);
      wr(7'h08, 8'h98);
      rd(7'h00, 8'h98);
      rd(7'h08, 8'h98);
      tdone("indirect");
      a = 8'($random(seed));
      b = 8'($random(seed));
      wr(7'h05, a);
      wr(7'h06, b);
      chk("latch_a", first_io_port_latch, a);
      chk("latch_b", second_io_port_latch, b[5:0]);
      for (int k = 0; k < 2; k++)
      begin
         port_readback_option = k[0];
         first_io_port_pins = 8'($random(seed));
         first_io_port_is_out = 8'($random(seed));
         second_io_port_pins = 6'($random(seed));
         second_io_port_is_out = 6'($random(seed));
         rd(7'h05, pexp(first_io_port_pins, first_io_port_is_out, a, k[0]));
         rd(7'h06, pexp({b[7:6], second_io_port_pins}, {2'b00, second_io_port_is_out}, b,
            k[0]));
      end
      tdone("ports");
      for (int s = 0; s < 3; s++)
      begin
         {cfg_t0_low_osc, timer0_source_mode} = {s == 2, s != 0};
         d = 8'($random(seed));
         wr(7'h01, d);
         repeat (3)
         begin
            @(negedge sys_clk) {low_osc_clock, external_count_input, instruction_clock} = 3'b001 << s;
            @(negedge sys_clk) {low_osc_clock, external_count_input, instruction_clock} = 3'b000;
         end
         repeat (2) @(negedge sys_clk);
         rd(7'h01, d + 8'd3);
      end
      tdone("timer0");
      @(negedge sys_clk) inst_done = 1'b1;
      repeat (3) @(negedge sys_clk);
      inst_done = 1'b0;
      chk("pc_step", pc_out, 11'h003);
      wr(7'h0A, 8'h45);
      chk("speedup", crystal_speedup_stop, 1'b1);
      rd(7'h0A, 8'h05);
      chk("speedup", crystal_speedup_stop, 1'b0);
      d = 8'($random(seed));
      inst_done = 1'b1;
      wr(7'h02, d);
      inst_done = 1'b0;
      chk("pc_load", pc_out, {3'h5, d});
      rd(7'h02, d);
      t = 11'($random(seed));
      @(negedge sys_clk) {inst_done, long_jump_instruction, inst_target} = {2'b11, t};
      @(negedge sys_clk) {inst_done, long_jump_instruction} = 2'b00;
      chk("pc_jump", pc_out, t);
      @(negedge sys_clk) {inst_done, long_call_instruction, inst_target} = {2'b11, ~t};
      @(negedge sys_clk) {inst_done, long_call_instruction} = 2'b00;
      chk("pc_call", pc_out, ~t);
      chk("push", stack_push, 1'b1);
      chk("push_addr", stack_push_addr, t + 11'd1);
      @(negedge sys_clk) chk("push_end", stack_push, 1'b0);
      tdone("program_counter");
      final_report();
   end
endmodule // core_sfr_bank_tb_top

// file: core_sfr_pkg.sv
// constants and types for the core special-function register bank
package core_sfr_pkg;
   // register locations within the special-function area
   localparam logic [6:0] ADDR_INDIRECT_PORT  = 7'h00;
   localparam logic [6:0] ADDR_TIMER0_COUNT   = 7'h01;
   localparam logic [6:0] ADDR_PC_LOW         = 7'h02;
   localparam logic [6:0] ADDR_STATUS_FLAGS   = 7'h03;
   localparam logic [6:0] ADDR_INDIRECT_PTR   = 7'h04;
   localparam logic [6:0] ADDR_FIRST_PORT     = 7'h05;
   localparam logic [6:0] ADDR_SECOND_PORT    = 7'h06;
   localparam logic [6:0] ADDR_POWER_CONTROL  = 7'h08;
   localparam logic [6:0] ADDR_WAKEUP_ENABLE  = 7'h09;
   localparam logic [6:0] ADDR_PC_HIGH_BUF    = 7'h0A;
   localparam logic [6:0] ADDR_PULL_LOW_CTRL  = 7'h0B;
   localparam logic [1:0] SFR_AREA_TOP        = 2'h0;  // locations 0x00..0x1F
   // widths
   localparam int PC_W        = 11;
   localparam int LOC_W       = 7;
   localparam int BANK_W      = 2;
   localparam int MEM_ADDR_W  = BANK_W + LOC_W;
   localparam int PCH_W       = 3;
   localparam int WAKE_W      = 6;
   localparam int SECOND_IO_W = 6;
   // status, pointer spare and high-buffer speed-up field positions
   localparam int ST_CARRY    = 0;
   localparam int ST_NIBBLE   = 1;
   localparam int ST_ZERO     = 2;
   localparam int ST_PDOWN    = 3;
   localparam int ST_TIMEOUT  = 4;
   localparam int ST_SPARE    = 5;
   localparam int ST_BANK_LO  = 6;
   localparam int PTR_SPARE   = 7;
   localparam int PCH_SPEEDUP = 6;
   // power control field positions
   localparam int PW_WDT      = 7;
   localparam int PW_LVD      = 5;
   localparam int PW_PULLHI5  = 4;
   localparam int PW_LVR      = 3;
   // reset values
   localparam logic [7:0]  POWER_CONTROL_RESET    = 8'h98;
   localparam logic [7:0]  PULLLOW_RESET = 8'hFF;
   localparam logic [5:0]  WAKE_RESET    = 6'h3F;
   localparam logic [2:0]  PCH_RESET     = 3'h0;
   localparam logic [10:0] PC_RESET      = 11'h000;
   localparam logic [1:0]  BANK_RESET    = 2'h0;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;
   // timer0 count source
   typedef enum logic [1:0] {
      T0_SRC_INST = 2'b00,
      T0_SRC_EXT  = 2'b01,
      T0_SRC_LOW  = 2'b10
   } t0_src_t;
endpackage
